// >>> common/sbt_defines.vh
`ifndef SBT_DEFINES_VH
`define SBT_DEFINES_VH

// register addresses
`define SBT_ADDR_CNT_LO 3'h0
`define SBT_ADDR_CNT_HI 3'h1
`define SBT_ADDR_CTRL 3'h2
`define SBT_ADDR_FLAG 3'h3
`define SBT_ADDR_IEN 3'h4
`define SBT_ADDR_CMP_LO 3'h5
`define SBT_ADDR_CMP_HI 3'h6
`define SBT_ADDR_CMP_MODE 3'h7

// timer_control_reg fields
`define SBT_CTRL_ON 0
`define SBT_CTRL_EXT_SRC 1
`define SBT_CTRL_ASYNC 2
`define SBT_CTRL_OSC_EN 3
`define SBT_CTRL_PS_LO 4
`define SBT_CTRL_PS_HI 5
`define SBT_CTRL_WIDE 7

// flag and enable fields
`define SBT_FLAG_OVF 0
`define SBT_IEN_OVF 0

// compare mode register fields
`define SBT_MODE1_LO 0
`define SBT_MODE1_HI 3
`define SBT_MODE2_LO 4
`define SBT_MODE2_HI 7
`define SBT_MODE_TRIGGER 4'hB

// reset values
`define SBT_CTRL_RST 8'h00
`define SBT_CNT_RST 16'h0000
`define SBT_CMP_RST 16'hFFFF
`define SBT_MODE_RST 8'h00
`define SBT_CNT_MAX 16'hFFFF
`define SBT_CNT_ZERO 16'h0000
`define SBT_PS_ZERO 3'h0
`define SBT_BUF_RST 8'h00

// last prescaler count before a counting tick, per ratio
`define SBT_PS_LAST_1 3'h0
`define SBT_PS_LAST_2 3'h1
`define SBT_PS_LAST_4 3'h3
`define SBT_PS_LAST_8 3'h7

`endif

// >>> hw/sbt_timer.v
// Operation
// - secondary oscillator runs only while control bit 3 is set.
// - oscillator keeps running during processor sleep.
// - counter counts up 0000h to FFFFh and wraps to 0000h.
// - wrap sets latched overflow flag, bit 0 of flag register.
// - interrupt request only while overflow enable bit 0 is set.
// - compare mode 1011 trigger resets the counter; code ignores both triggers in async mode.
// - second unit trigger also starts conversion when converter enabled.
// - first unit trigger reset does not set overflow flag.
// - counter write coinciding with first unit trigger wins over reset.
// - first unit compare pair acts as the counter period.
// - wide access bit 7 maps high-byte address onto a buffer.
// - wide mode low-byte read copies counter high byte into buffer.
// - wide mode low-byte write loads high byte from buffer together.
// - wide mode high-byte accesses only reach the buffer.
// - prescaler cleared on low-byte writes only.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sbt_defines.vh"

module sbt_timer #(
  parameter CNT_W = 16,
  parameter PS_W = 3
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire sleep,
  input wire sec_osc_input_pin,
  output wire sec_osc_output_pin,
  output wire sec_osc_running,
  input wire second_unit_trigger,
  input wire adc_enabled,
  output reg adc_start,
  output reg first_unit_trigger,
  output wire counter_overflow_irq
);

  reg [7:0] timer_control_reg;
  reg [CNT_W-1:0] count;
  reg [7:0] high_buf;
  reg [PS_W-1:0] prescale;
  reg [CNT_W-1:0] compare_value;
  reg [7:0] compare_mode;
  reg counter_overflow_flag;
  reg counter_overflow_irq_enable;
  reg osc_prev;

  reg [CNT_W-1:0] next_count;
  reg [PS_W-1:0] next_prescale;
  reg [7:0] next_high_buf;
  reg next_overflow;
  reg [7:0] read_mux;

  wire wide_access_enable = timer_control_reg[`SBT_CTRL_WIDE];
  wire sec_osc_enable = timer_control_reg[`SBT_CTRL_OSC_EN];
  wire timer_on = timer_control_reg[`SBT_CTRL_ON];
  wire ext_src = timer_control_reg[`SBT_CTRL_EXT_SRC];
  wire async_mode = timer_control_reg[`SBT_CTRL_ASYNC];
  wire [1:0] ps_sel = timer_control_reg[`SBT_CTRL_PS_HI:`SBT_CTRL_PS_LO];
  wire [3:0] mode1 = compare_mode[`SBT_MODE1_HI:`SBT_MODE1_LO];
  wire [3:0] mode2 = compare_mode[`SBT_MODE2_HI:`SBT_MODE2_LO];

  // oscillator amplifier: gated only by its enable, never by sleep
  assign sec_osc_running = sec_osc_enable;
  assign sec_osc_output_pin = sec_osc_enable & ~sec_osc_input_pin;

  wire wr_lo = reg_wr && (reg_addr == `SBT_ADDR_CNT_LO);
  wire wr_hi = reg_wr && (reg_addr == `SBT_ADDR_CNT_HI);
  wire rd_lo = reg_rd && (reg_addr == `SBT_ADDR_CNT_LO);

  // external edges only count while the oscillator runs; internal ticks stop in sleep
  wire osc_rise = sec_osc_enable & sec_osc_input_pin & ~osc_prev;
  wire src_tick = timer_on & (ext_src ? osc_rise : ~sleep);

  // prescale ratio 1, 2, 4 or 8
  wire [PS_W-1:0] ps_last = (ps_sel == 2'h0) ? `SBT_PS_LAST_1 :
                            (ps_sel == 2'h1) ? `SBT_PS_LAST_2 :
                            (ps_sel == 2'h2) ? `SBT_PS_LAST_4 : `SBT_PS_LAST_8;
  wire cnt_tick = src_tick && (prescale == ps_last);

  // trigger resets are not honoured in asynchronous counting
  wire trig1_mode = (mode1 == `SBT_MODE_TRIGGER) && !async_mode;
  wire trig2_mode = (mode2 == `SBT_MODE_TRIGGER) && !async_mode;
  wire period_hit = cnt_tick && trig1_mode && (count == compare_value);
  wire trig2_hit = second_unit_trigger && trig2_mode;

  always @* begin
    next_count = count;
    next_prescale = prescale;
    next_high_buf = high_buf;
    next_overflow = 1'b0;
    if (src_tick) begin
      if (cnt_tick) begin
        next_prescale = `SBT_PS_ZERO;
      end else begin
        next_prescale = prescale + 3'h1;
      end
    end
    if (cnt_tick) begin
      if (period_hit) begin
        next_count = `SBT_CNT_ZERO;
      end else if (count == `SBT_CNT_MAX) begin
        next_count = `SBT_CNT_ZERO;
        next_overflow = 1'b1;
      end else begin
        next_count = count + 16'h0001;
      end
    end
    if (trig2_hit) begin
      next_count = `SBT_CNT_ZERO;
      next_overflow = 1'b0;
    end
    // a low-byte write, or a high-byte write outside wide mode, overrides any trigger reset in the same cycle
    if (wr_lo) begin
      next_prescale = `SBT_PS_ZERO;
      next_overflow = 1'b0;
      if (wide_access_enable) begin
        next_count = {high_buf, reg_wdata};
      end else begin
        next_count = {count[15:8], reg_wdata};
      end
    end else if (wr_hi) begin
      if (wide_access_enable) begin
        next_high_buf = reg_wdata;
      end else begin
        next_count = {reg_wdata, count[7:0]};
        next_overflow = 1'b0;
      end
    end
    if (rd_lo && wide_access_enable) begin
      next_high_buf = count[15:8];
    end
  end

  always @* begin
    case (reg_addr)
      `SBT_ADDR_CNT_LO: read_mux = count[7:0];
      `SBT_ADDR_CNT_HI: read_mux = wide_access_enable ? high_buf : count[15:8];
      `SBT_ADDR_CTRL: read_mux = timer_control_reg;
      `SBT_ADDR_FLAG: read_mux = {7'h00, counter_overflow_flag};
      `SBT_ADDR_IEN: read_mux = {7'h00, counter_overflow_irq_enable};
      `SBT_ADDR_CMP_LO: read_mux = compare_value[7:0];
      `SBT_ADDR_CMP_HI: read_mux = compare_value[15:8];
      `SBT_ADDR_CMP_MODE: read_mux = compare_mode;
      default: read_mux = 8'h00;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_reg <= `SBT_CTRL_RST;
      count <= `SBT_CNT_RST;
      high_buf <= `SBT_BUF_RST;
      prescale <= `SBT_PS_ZERO;
      compare_value <= `SBT_CMP_RST;
      compare_mode <= `SBT_MODE_RST;
      counter_overflow_flag <= 1'b0;
      counter_overflow_irq_enable <= 1'b0;
      osc_prev <= 1'b0;
      reg_rdata <= 8'h00;
      adc_start <= 1'b0;
      first_unit_trigger <= 1'b0;
    end else begin
      osc_prev <= sec_osc_input_pin;
      count <= next_count;
      prescale <= next_prescale;
      high_buf <= next_high_buf;
      reg_rdata <= reg_rd ? read_mux : 8'h00;
      adc_start <= trig2_hit && adc_enabled;
      first_unit_trigger <= period_hit;
      if (reg_wr && reg_addr == `SBT_ADDR_CTRL) begin
        timer_control_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == `SBT_ADDR_IEN) begin
        counter_overflow_irq_enable <= reg_wdata[`SBT_IEN_OVF];
      end
      if (reg_wr && reg_addr == `SBT_ADDR_CMP_LO) begin
        compare_value[7:0] <= reg_wdata;
      end
      if (reg_wr && reg_addr == `SBT_ADDR_CMP_HI) begin
        compare_value[15:8] <= reg_wdata;
      end
      if (reg_wr && reg_addr == `SBT_ADDR_CMP_MODE) begin
        compare_mode <= reg_wdata;
      end
      // a wrap in the clearing cycle still sets the flag
      if (next_overflow) begin
        counter_overflow_flag <= 1'b1;
      end else if (reg_wr && reg_addr == `SBT_ADDR_FLAG) begin
        counter_overflow_flag <= reg_wdata[`SBT_FLAG_OVF];
      end
    end
  end

  assign counter_overflow_irq = counter_overflow_flag & counter_overflow_irq_enable;

endmodule // sbt_timer

`default_nettype wire

// >>> bench/sbt_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sbt_chk (
  input wire ref_clk,
  input wire rst_n,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire sleep,
  input wire sec_osc_input_pin,
  input wire sec_osc_output_pin,
  input wire sec_osc_running,
  input wire second_unit_trigger,
  input wire adc_enabled,
  input wire adc_start,
  input wire first_unit_trigger,
  input wire counter_overflow_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_OSC_AMP: assert property (
    sec_osc_output_pin == (sec_osc_running & ~sec_osc_input_pin)) else $error("osc amp");
  AST_OSC_EN: assert property (
    reg_wr && reg_addr == 3'h2 |=> sec_osc_running == $past(reg_wdata[3])) else $error("osc en");
  AST_OSC_SLEEP: assert property (
    sleep && sec_osc_running && !reg_wr |=> sec_osc_running) else $error("osc sleep");
  AST_FLAG_HOLD: assert property (
    counter_overflow_irq && !reg_wr |=> counter_overflow_irq) else $error("flag hold");
  AST_IRQ_GATE: assert property (
    reg_wr && reg_addr == 3'h4 && !reg_wdata[0] |=> !counter_overflow_irq) else $error("irq");
  AST_ADC_CAUSE: assert property (
    adc_start |-> $past(second_unit_trigger && adc_enabled)) else $error("adc start");
  AST_PERIOD_NOFLAG: assert property (
    first_unit_trigger && !$past(reg_wr) |-> !$rose(counter_overflow_irq)) else $error("flag");
  AST_RD_IDLE: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("rdata idle");
endmodule // sbt_chk
bind sbt_timer sbt_chk i_sbt_chk (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .sleep(sleep),
  .sec_osc_input_pin(sec_osc_input_pin),
  .sec_osc_output_pin(sec_osc_output_pin),
  .sec_osc_running(sec_osc_running),
  .second_unit_trigger(second_unit_trigger),
  .adc_enabled(adc_enabled),
  .adc_start(adc_start),
  .first_unit_trigger(first_unit_trigger),
  .counter_overflow_irq(counter_overflow_irq)
);
`default_nettype wire

// >>> bench/sbt_partner.sv
`timescale 1ns/1ps
`default_nettype none
module sbt_partner (
  input wire logic clk,
  input wire logic run,
  input wire logic fire,
  output logic osc,
  output logic trig
);
  logic [1:0] div = 2'h0;
  initial {osc, trig} = 2'h0;
  // crystal swings only while enabled, rests low otherwise
  always @(posedge clk) begin
    div <= div + 2'h1;
    osc <= run & div[1];
    trig <= fire;
  end
endmodule // sbt_partner
`default_nettype wire

// >>> bench/sbt_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module sbt_timer_tb;
  logic ref_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, sleep = 1'h0;
  logic adc_enabled = 1'h0, fire = 1'h0, rd_q = 1'h0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, h, l;
  logic [15:0] note;
  logic [15:0] exp_q[$];
  wire [7:0] reg_rdata;
  wire osc_in, osc_run, trig2, adc_start, trig1, irq;
  int bad_count = 0, checks_done = 0, i;
  always #4 ref_clk = ~ref_clk;
  sbt_timer i_sbt_timer (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sleep, .sec_osc_input_pin(osc_in), .sec_osc_output_pin(), .sec_osc_running(osc_run),
    .second_unit_trigger(trig2), .adc_enabled, .adc_start, .first_unit_trigger(trig1),
    .counter_overflow_irq(irq));
  sbt_partner i_sbt_partner (.clk(ref_clk), .run(osc_run), .fire, .osc(osc_in), .trig(trig2));
  always @(posedge ref_clk) begin
    if (rd_q) begin
      note = exp_q.pop_front();
      `CHK("read data", note[7:0], reg_rdata & note[15:8])
    end
    rd_q <= reg_rd;
  end
  // a gap cycle after each strobe keeps one driver edge per strobe change
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({m, e});
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    print_verdict;
  end
  initial begin
    i = $urandom(83);
    h = 8'($urandom);
    l = 8'($urandom);
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    wr(3'h1, h);
    wr(3'h0, l);
    rd(3'h1, 8'hFF, h);
    wr(3'h2, 8'h80);
    wr(3'h1, ~h);
    wr(3'h0, l);
    wr(3'h1, h);
    rd(3'h0, 8'hFF, l);
    rd(3'h1, 8'hFF, ~h);
    wr(3'h2, 8'h00);
    wr(3'h1, 8'hFF);
    wr(3'h0, 8'hFD);
    wr(3'h4, 8'h01);
    wr(3'h2, 8'h01);
    repeat (4) @(posedge ref_clk);
    `CHK("irq", 1'h1, irq)
    rd(3'h3, 8'h01, 8'h01);
    rd(3'h1, 8'hFF, 8'h00);
    wr(3'h4, 8'h00);
    `CHK("irq masked", 1'h0, irq)
    wr(3'h3, 8'h00);
    rd(3'h3, 8'h01, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h5, 8'h05);
    wr(3'h6, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h00);
    wr(3'h4, 8'h01);
    wr(3'h7, 8'h0B);
    wr(3'h2, 8'h01);
    for (i = 0; i < 20 && trig1 !== 1'h1; i++) @(posedge ref_clk);
    `CHK("period pulse", 1'h1, trig1)
    `CHK("no flag", 1'h0, irq)
    rd(3'h1, 8'hFF, 8'h00);
    rd(3'h0, 8'hF8, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h01);
    repeat (4) @(posedge ref_clk);
    wr(3'h0, 8'h80);
    rd(3'h0, 8'hF0, 8'h80);
    wr(3'h7, 8'hB0);
    wr(3'h1, 8'h40);
    for (i = 0; i < 2; i++) begin
      adc_enabled <= (i == 0);
      fire <= 1'h1;
      @(posedge ref_clk);
      fire <= 1'h0;
      repeat (2) @(posedge ref_clk);
      `CHK("adc start", (i == 0), adc_start)
    end
    rd(3'h1, 8'hFF, 8'h00);
    wr(3'h2, 8'h05);
    wr(3'h1, 8'h40);
    fire <= 1'h1;
    @(posedge ref_clk);
    fire <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rd(3'h1, 8'hFF, 8'h40);
    wr(3'h2, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h31);
    wr(3'h1, 8'h00);
    repeat (30) @(posedge ref_clk);
    rd(3'h0, 8'hFF, 8'h04);
    wr(3'h0, 8'h00);
    repeat (12) @(posedge ref_clk);
    rd(3'h0, 8'hFF, 8'h01);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h00);
    sleep <= 1'h1;
    wr(3'h2, 8'h01);
    repeat (10) @(posedge ref_clk);
    rd(3'h0, 8'hFF, 8'h00);
    wr(3'h2, 8'h0B);
    repeat (40) @(posedge ref_clk);
    rd(3'h0, 8'hF8, 8'h08);
    `CHK("osc run", 1'h1, osc_run)
    sleep <= 1'h0;
    print_verdict;
  end
endmodule // sbt_timer_tb
`default_nettype wire
